// ==== hdl/rsc_regs.vh ====
// Register map, field layout and reset values of the ramp spread controller
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSC_OFS_MODE 8'h6b
`define RSC_OFS_RANGE 8'h6c
`define RSC_OFS_DIV 8'h6d
`define RSC_OFS_STEP 8'h6e
`define RSC_OFS_AMPB 8'h6f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSC_RST_MODE 8'h00
`define RSC_RST_RANGE 8'h00
`define RSC_RST_DIV 8'h50
`define RSC_RST_STEP 8'h11
`define RSC_RST_AMPB 8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSC_MODE_TRI_EN 0
`define RSC_MODE_RDM_EN 1
`define RSC_MODE_MANUAL 4
`define RSC_MODE_PREDIV 5
`define RSC_RANGE_TRI 3:0
`define RSC_RANGE_RDM 6:4
`define RSC_STEP_FALL 7:4
`define RSC_STEP_RISE 3:0
`define RSC_AMPB_AMP 6:5
`define RSC_AMPB_BOUND 4:0

// ----------------------------------------
// Internal choices used outside manual mode
// ----------------------------------------
`define RSC_AUTO_STEP 4'h1
`define RSC_AUTO_AMP 2'h1
`define RSC_LFSR_SEED 8'h5a

`endif

// ==== hdl/rsc_tri_sweep.v ====
// Triangle sweep of the ramp period offset between +bound and -bound
module rsc_tri_sweep #(
   parameter STEP_W = 4,
   parameter BOUND_W = 5,
   parameter OFS_W = 8
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Control
   input wire sweep_en,
   input wire sweep_tick,
   input wire [STEP_W-1:0] rise_step,
   input wire [STEP_W-1:0] fall_step,
   input wire [BOUND_W-1:0] bound,
   // Result, two's complement
   output wire [OFS_W-1:0] offset
);

   reg [OFS_W-1:0] ofs_ff;
   reg [OFS_W-1:0] nxt_ofs;
   reg down_ff;
   reg nxt_down;
   wire signed [OFS_W-1:0] pos_b;
   wire signed [OFS_W-1:0] neg_b;
   wire signed [OFS_W-1:0] up_v;
   wire signed [OFS_W-1:0] dn_v;

   assign pos_b = {{(OFS_W-BOUND_W){1'b0}}, bound};
   assign neg_b = -pos_b;
   assign up_v = $signed(ofs_ff) + $signed({{(OFS_W-STEP_W){1'b0}}, rise_step});
   assign dn_v = $signed(ofs_ff) - $signed({{(OFS_W-STEP_W){1'b0}}, fall_step});
   assign offset = ofs_ff;

   // ----------------------------------------
   // Sweep step
   // ----------------------------------------
   always @* begin
      nxt_ofs = ofs_ff;
      nxt_down = down_ff;
      if (!sweep_en) begin
         nxt_ofs = {OFS_W{1'b0}};
         nxt_down = 1'b0;
      end else if (sweep_tick) begin
         if (!down_ff) begin
            // Clamp at the bound so a large step never overshoots
            if (up_v >= pos_b) begin
               nxt_ofs = pos_b;
               nxt_down = 1'b1;
            end else begin
               nxt_ofs = up_v;
            end
         end else begin
            if (dn_v <= neg_b) begin
               nxt_ofs = neg_b;
               nxt_down = 1'b0;
            end else begin
               nxt_ofs = dn_v;
            end
         end
      end
   end

   always @(posedge mclk) begin
      if (rst) begin
         ofs_ff <= {OFS_W{1'b0}};
         down_ff <= 1'b0;
      end else begin
         ofs_ff <= nxt_ofs;
         down_ff <= nxt_down;
      end
   end

endmodule // rsc_tri_sweep

// ==== hdl/rsc_ramp_spread_ctrl.v ====
// Ramp spread controller: control registers and spread carrier period generation
//
// Summary of operation
// - Mode bit 0 enables triangle spreading
// - Mode bit 1 enables random spreading
// - Mode bit 4 selects manual parameters
// - Manual bit 5 halves the source clock
// - Manual ramp frequency is source over N
// - Step bits 7-4 give manual falling step
// - Step bits 3-0 give manual rising step
// - Bits 6-5 set ramp amplitude manually
// - Bits 4-0 bound the triangle sweep manually
`include "rsc_regs.vh"

module rsc_ramp_spread_ctrl #(
   parameter DATA_W = 8,
   parameter PER_W = 10,
   parameter OFS_W = 8
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register access
   input wire [7:0] reg_addr,
   input wire [DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [DATA_W-1:0] reg_rdata,
   output wire reg_rvalid,
   // Ramp control
   output wire ramp_tick,
   output wire [PER_W-1:0] ramp_period,
   output wire [1:0] ramp_amp,
   output wire manual_active,
   output wire spread_active
);

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   reg [DATA_W-1:0] spread_mode_control_ff;
   reg [DATA_W-1:0] spread_range_control_ff;
   reg [DATA_W-1:0] manual_ramp_divisor_ff;
   reg [DATA_W-1:0] triangle_step_control_ff;
   reg [DATA_W-1:0] ramp_amplitude_boundary_ff;
   reg [DATA_W-1:0] reg_rdata_ff;
   reg [DATA_W-1:0] nxt_rdata;
   reg reg_rvalid_ff;

   // Reserved bits are stored and read back but drive nothing
   always @(posedge mclk) begin
      if (rst) begin
         spread_mode_control_ff <= `RSC_RST_MODE;
         spread_range_control_ff <= `RSC_RST_RANGE;
         manual_ramp_divisor_ff <= `RSC_RST_DIV;
         triangle_step_control_ff <= `RSC_RST_STEP;
         ramp_amplitude_boundary_ff <= `RSC_RST_AMPB;
      end else if (reg_wr) begin
         case (reg_addr)
            `RSC_OFS_MODE: spread_mode_control_ff <= reg_wdata;
            `RSC_OFS_RANGE: spread_range_control_ff <= reg_wdata;
            `RSC_OFS_DIV: manual_ramp_divisor_ff <= reg_wdata;
            `RSC_OFS_STEP: triangle_step_control_ff <= reg_wdata;
            `RSC_OFS_AMPB: ramp_amplitude_boundary_ff <= reg_wdata;
            // Unmapped writes are dropped; no error is flagged
            default: ;
         endcase
      end
   end

   always @* begin
      case (reg_addr)
         `RSC_OFS_MODE: nxt_rdata = spread_mode_control_ff;
         `RSC_OFS_RANGE: nxt_rdata = spread_range_control_ff;
         `RSC_OFS_DIV: nxt_rdata = manual_ramp_divisor_ff;
         `RSC_OFS_STEP: nxt_rdata = triangle_step_control_ff;
         `RSC_OFS_AMPB: nxt_rdata = ramp_amplitude_boundary_ff;
         default: nxt_rdata = {DATA_W{1'b0}};
      endcase
   end

   // Read data holds until the next read, so a slow master may take it late
   always @(posedge mclk) begin
      if (rst) begin
         reg_rdata_ff <= {DATA_W{1'b0}};
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= reg_rd;
         if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

   assign reg_rdata = reg_rdata_ff;
   assign reg_rvalid = reg_rvalid_ff;

   // ----------------------------------------
   // Field decode and mode selection
   // ----------------------------------------
   wire tri_en;
   wire rdm_en;
   wire manual;
   wire pre_div;
   wire [3:0] triangle_fall_step;
   wire [3:0] triangle_rise_step;
   wire [1:0] ramp_amplitude_setting;
   wire [4:0] triangle_period_bound;
   wire [7:0] manual_ramp_divisor_n;
   wire [2:0] random_spread_range;
   wire [3:0] tri_range;
   wire [3:0] eff_rise;
   wire [3:0] eff_fall;
   wire [4:0] eff_bound;
   wire [7:0] eff_div;
   wire [1:0] eff_amp;
   wire eff_prediv;

   assign tri_en = spread_mode_control_ff[`RSC_MODE_TRI_EN];
   assign rdm_en = spread_mode_control_ff[`RSC_MODE_RDM_EN];
   assign manual = spread_mode_control_ff[`RSC_MODE_MANUAL];
   assign pre_div = spread_mode_control_ff[`RSC_MODE_PREDIV];
   // Mode bits 7-6 and 3-2 are reserved and never decoded
   assign tri_range = spread_range_control_ff[`RSC_RANGE_TRI];
   assign random_spread_range = spread_range_control_ff[`RSC_RANGE_RDM];
   assign manual_ramp_divisor_n = manual_ramp_divisor_ff;
   assign triangle_fall_step = triangle_step_control_ff[`RSC_STEP_FALL];
   assign triangle_rise_step = triangle_step_control_ff[`RSC_STEP_RISE];
   assign ramp_amplitude_setting = ramp_amplitude_boundary_ff[`RSC_AMPB_AMP];
   assign triangle_period_bound = ramp_amplitude_boundary_ff[`RSC_AMPB_BOUND];

   // Outside manual mode every manual field is ignored
   assign eff_prediv = manual & pre_div;
   assign eff_div = manual ? manual_ramp_divisor_n : `RSC_RST_DIV;
   assign eff_fall = manual ? triangle_fall_step : `RSC_AUTO_STEP;
   assign eff_rise = manual ? triangle_rise_step : `RSC_AUTO_STEP;
   assign eff_amp = manual ? ramp_amplitude_setting : `RSC_AUTO_AMP;
   // Auto mode derives the sweep range from the triangle range field
   assign eff_bound = manual ? triangle_period_bound : {1'b0, tri_range};

   // ----------------------------------------
   // Source clock enable
   // ----------------------------------------
   reg half_ff;

   // Pre-divide realised as an every-other-cycle enable to keep one clock
   always @(posedge mclk) begin
      if (rst) begin
         half_ff <= 1'b0;
      end else if (eff_prediv) begin
         half_ff <= ~half_ff;
      end else begin
         half_ff <= 1'b0;
      end
   end

   // Only manual mode may halve the count rate
   wire src_en;
   assign src_en = ~eff_prediv | half_ff;

   // ----------------------------------------
   // Triangle sweep
   // ----------------------------------------
   // Sweep moves once per ramp period, on the tick
   wire [OFS_W-1:0] tri_ofs;
   reg ramp_tick_ff;

   rsc_tri_sweep #(
      .STEP_W(4),
      .BOUND_W(5),
      .OFS_W(OFS_W)
   ) u_tri (
      .mclk(mclk),
      .rst(rst),
      .sweep_en(tri_en),
      .sweep_tick(ramp_tick_ff),
      .rise_step(eff_rise),
      .fall_step(eff_fall),
      .bound(eff_bound),
      .offset(tri_ofs)
   );

   // ----------------------------------------
   // Random spread
   // ----------------------------------------
   reg [7:0] lfsr_ff;
   wire lfsr_fb;
   reg [6:0] rdm_mask;
   wire [6:0] rdm_ofs;

   assign lfsr_fb = lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3];

   // Advance once per ramp period so each period gets a fresh offset
   always @(posedge mclk) begin
      if (rst) begin
         lfsr_ff <= `RSC_LFSR_SEED;
      end else if (lfsr_ff == {8{1'b0}}) begin
         // All-zero state would lock the sequence, so reseed
         lfsr_ff <= `RSC_LFSR_SEED;
      end else if (ramp_tick_ff) begin
         lfsr_ff <= {lfsr_ff[6:0], lfsr_fb};
      end
   end

   always @* begin
      case (random_spread_range)
         3'h0: rdm_mask = 7'h00;
         3'h1: rdm_mask = 7'h01;
         3'h2: rdm_mask = 7'h03;
         3'h3: rdm_mask = 7'h07;
         3'h4: rdm_mask = 7'h0f;
         3'h5: rdm_mask = 7'h1f;
         3'h6: rdm_mask = 7'h3f;
         default: rdm_mask = 7'h7f;
      endcase
   end

   // Random offset only lengthens the period, never shortens it
   assign rdm_ofs = rdm_en ? (lfsr_ff[6:0] & rdm_mask) : 7'h00;

   // ----------------------------------------
   // Period computation
   // ----------------------------------------
   wire [PER_W-1:0] div_ext;
   wire [PER_W-1:0] tri_ext;
   wire [PER_W-1:0] rdm_ext;
   wire [PER_W-1:0] sum_per;
   wire [PER_W-1:0] tgt_per;

   // Triangle offset is two's complement, so it is sign-extended
   assign div_ext = {{(PER_W-8){1'b0}}, eff_div};
   assign tri_ext = {{(PER_W-OFS_W){tri_ofs[OFS_W-1]}}, tri_ofs};
   assign rdm_ext = {{(PER_W-7){1'b0}}, rdm_ofs};
   assign sum_per = div_ext + tri_ext + rdm_ext;
   // A zero or negative period would stall the ramp, so floor it at one
   assign tgt_per = (sum_per[PER_W-1] || (sum_per == {PER_W{1'b0}}))
      ? {{(PER_W-1){1'b0}}, 1'b1} : sum_per;

   // ----------------------------------------
   // Ramp period counter
   // ----------------------------------------
   reg [PER_W-1:0] cnt_ff;
   reg [PER_W-1:0] nxt_cnt;
   reg [PER_W-1:0] per_ff;
   reg nxt_tick;

   // Compare is >= so a period that shrinks mid-count ends at once
   always @* begin
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      if (src_en) begin
         if (cnt_ff >= per_ff - {{(PER_W-1){1'b0}}, 1'b1}) begin
            nxt_cnt = {PER_W{1'b0}};
            nxt_tick = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + {{(PER_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // New period takes effect only at a period boundary to avoid glitches
   always @(posedge mclk) begin
      if (rst) begin
         cnt_ff <= {PER_W{1'b0}};
         per_ff <= {{(PER_W-8){1'b0}}, `RSC_RST_DIV};
         ramp_tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         ramp_tick_ff <= nxt_tick;
         if (nxt_tick) begin
            per_ff <= tgt_per;
         end
      end
   end

   // ----------------------------------------
   // Status outputs
   // ----------------------------------------
   // Amplitude is only reported here; it shapes nothing inside
   reg [1:0] amp_ff;
   reg manual_ff;
   reg spread_ff;

   always @(posedge mclk) begin
      if (rst) begin
         amp_ff <= `RSC_AUTO_AMP;
         manual_ff <= 1'b0;
         spread_ff <= 1'b0;
      end else begin
         amp_ff <= eff_amp;
         manual_ff <= manual;
         spread_ff <= tri_en | rdm_en;
      end
   end

   assign ramp_tick = ramp_tick_ff;
   assign ramp_period = per_ff;
   assign ramp_amp = amp_ff;
   assign manual_active = manual_ff;
   assign spread_active = spread_ff;

endmodule // rsc_ramp_spread_ctrl

// ==== tb/rsc_ramp_spread_checker.sv ====
// Port-level assertions for the ramp spread controller
module rsc_ramp_spread_checker #(
   parameter DATA_W = 8,
   parameter PER_W = 10,
   parameter OFS_W = 8
) (
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register access
   input wire [7:0] reg_addr,
   input wire [DATA_W-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [DATA_W-1:0] reg_rdata,
   input wire reg_rvalid,
   // Ramp control
   input wire ramp_tick,
   input wire [PER_W-1:0] ramp_period,
   input wire [1:0] ramp_amp,
   input wire manual_active,
   input wire spread_active
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   wire mapped = reg_addr >= 8'h6b && reg_addr <= 8'h6f;
   wire mode_wr = reg_wr && reg_addr == 8'h6b;

   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read answer missing");
   a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read valid without read");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_write_readback: assert property (reg_wr && !reg_rd && mapped ##1 !reg_wr ##1
      reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2) |=> reg_rdata == $past(reg_wdata, 3))
      else $error("read back differs from write");
   a_manual_follow: assert property (mode_wr ##1 !mode_wr |=>
      manual_active == $past(reg_wdata[4], 2))
      else $error("manual flag wrong");
   a_spread_follow: assert property (mode_wr ##1 !mode_wr |=>
      spread_active == $past(|reg_wdata[1:0], 2))
      else $error("spread flag wrong");
   a_period_at_tick: assert property ($changed(ramp_period) |-> ramp_tick)
      else $error("period changed off boundary");
endmodule // rsc_ramp_spread_checker

bind rsc_ramp_spread_ctrl rsc_ramp_spread_checker #(.DATA_W(DATA_W), .PER_W(PER_W),
   .OFS_W(OFS_W)) chk_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .ramp_tick(ramp_tick), .ramp_period(ramp_period),
   .ramp_amp(ramp_amp), .manual_active(manual_active), .spread_active(spread_active));

// ==== tb/tb.sv ====
// Self-checking bench for the ramp spread controller
`include "rsc_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] reg_addr = 8'h00;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   wire [7:0] reg_rdata;
   wire reg_rvalid, ramp_tick, manual_active, spread_active;
   wire [9:0] ramp_period;
   wire [1:0] ramp_amp;
   integer num_errors = 0;
   integer checks_done = 0;
   always #50 mclk = ~mclk;
   rsc_ramp_spread_ctrl dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .ramp_tick(ramp_tick), .ramp_period(ramp_period),
      .ramp_amp(ramp_amp), .manual_active(manual_active), .spread_active(spread_active));
   // ----
   // Shared tasks
   // ----
   task results;
      begin
         $display("checks %0d mismatches %0d", checks_done, num_errors);
         if (num_errors == 0 && checks_done > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge mclk);
         reg_addr = a;
         reg_wdata = d;
         reg_wr = 1'b1;
         @(negedge mclk);
         reg_wr = 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(negedge mclk);
         reg_addr = a;
         reg_rd = 1'b1;
         @(negedge mclk);
         reg_rd = 1'b0;
         chk(reg_rvalid, 1'b1);
         d = reg_rdata;
      end
   endtask
   // Bounded so a dead ramp ends the run instead of hanging it
   task wtick;
      integer i;
      begin
         i = 0;
         @(negedge mclk);
         while (ramp_tick !== 1'b1 && i < 600) begin
            @(negedge mclk);
            i = i + 1;
         end
         if (i >= 600) begin
            num_errors = num_errors + 1;
            $display("Timeout waiting for ramp tick");
            results;
         end
      end
   endtask
   // Settles past the next two boundaries, then counts one full period
   task gap(output integer n);
      begin
         wtick;
         wtick;
         n = 1;
         @(negedge mclk);
         while (ramp_tick !== 1'b1 && n < 600) begin
            @(negedge mclk);
            n = n + 1;
         end
         if (n >= 600) begin
            num_errors = num_errors + 1;
            $display("Timeout counting a ramp period");
            results;
         end
      end
   endtask
   // ----
   // Scenarios
   // ----
   task t_reset;
      reg [7:0] d;
      integer n;
      begin
         rd(`RSC_OFS_MODE, d); chk(d, `RSC_RST_MODE);
         rd(`RSC_OFS_RANGE, d); chk(d, `RSC_RST_RANGE);
         rd(`RSC_OFS_DIV, d); chk(d, `RSC_RST_DIV);
         rd(`RSC_OFS_STEP, d); chk(d, `RSC_RST_STEP);
         rd(`RSC_OFS_AMPB, d); chk(d, `RSC_RST_AMPB);
         chk(ramp_amp, 2'h1);
         chk({manual_active, spread_active}, 2'h0);
         gap(n); chk(n, 80);
         $display("t_reset done");
      end
   endtask
   task t_regs;
      reg [7:0] d;
      integer a;
      begin
         for (a = 8'h6b; a <= 8'h6f; a = a + 1) begin
            wr(a, 8'hff);
            rd(a, d); chk(d, 8'hff);
         end
         wr(8'h70, 8'hff);
         rd(8'h70, d); chk(d, 8'h00);
         rd(8'h6a, d); chk(d, 8'h00);
         @(negedge mclk);
         rst = 1'b1;
         repeat (3) @(negedge mclk);
         rst = 1'b0;
         $display("t_regs done");
         t_reset;
      end
   endtask
   task t_manual;
      integer n;
      begin
         wr(`RSC_OFS_DIV, 8'h20);
         wr(`RSC_OFS_AMPB, 8'h44);
         wr(`RSC_OFS_MODE, 8'h10);
         gap(n); chk(n, 32);
         chk(manual_active, 1'b1);
         chk(ramp_amp, 2'h2);
         wr(`RSC_OFS_MODE, 8'h30);
         gap(n); chk(n, 64);
         wr(`RSC_OFS_MODE, 8'h20);
         gap(n); chk(n, 80);
         chk(ramp_amp, 2'h1);
         $display("t_manual done");
      end
   endtask
   task t_tri;
      integer i, p, q, mx, mn, up, dn, bad;
      begin
         wr(`RSC_OFS_DIV, 8'h40);
         wr(`RSC_OFS_STEP, 8'h32);
         wr(`RSC_OFS_AMPB, 8'h26);
         wr(`RSC_OFS_MODE, 8'h11);
         wtick;
         wtick;
         chk(spread_active, 1'b1);
         q = ramp_period; mx = 0; mn = 999; up = 0; dn = 0; bad = 0;
         for (i = 0; i < 40; i = i + 1) begin
            wtick;
            @(negedge mclk);
            p = ramp_period;
            if (p - q == 2) up = 1;
            else if (p - q == -3) dn = 1;
            else if (p != q) bad = bad + 1;
            if (p > mx) mx = p;
            if (p < mn) mn = p;
            q = p;
         end
         chk(mx, 70);
         chk(mn, 58);
         chk({up[0], dn[0]}, 2'h3);
         chk(bad, 0);
         $display("t_tri done");
      end
   endtask
   task t_rdm;
      integer i, p, mx, mn, bad;
      begin
         wr(`RSC_OFS_RANGE, 8'h30);
         wr(`RSC_OFS_MODE, 8'h02);
         wtick;
         wtick;
         chk(spread_active, 1'b1);
         mx = 0; mn = 999; bad = 0;
         for (i = 0; i < 30; i = i + 1) begin
            wtick;
            @(negedge mclk);
            p = ramp_period;
            if (p < 80 || p > 87) bad = bad + 1;
            if (p > mx) mx = p;
            if (p < mn) mn = p;
         end
         chk(bad, 0);
         chk(mx > mn, 1'b1);
         $display("t_rdm done");
      end
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      t_reset;
      t_regs;
      t_manual;
      t_tri;
      t_rdm;
      results;
   end
endmodule // tb
